// *** audio_clock_pkg.sv ***
// Constants shared by the audio clock control and status block.
// Assumes a 200 MHz system clock and a host that reaches registers by subaddress.
package audio_clock_pkg;
  // Register subaddresses
  localparam logic [7:0] ADDR_CLOCK_RATE = 8'h00;
  localparam logic [7:0] ADDR_FIRMWARE_ID = 8'h01;
  localparam logic [7:0] ADDR_ERROR_FLAGS = 8'h02;
  localparam logic [7:0] ADDR_SYSTEM_ONE = 8'h03;
  // Values after reset, and the mask of implemented error flags
  localparam logic [7:0] CLOCK_RATE_RESET = 8'h6C;
  localparam logic [7:0] SYSTEM_ONE_RESET = 8'hA0;
  localparam logic [7:0] ERROR_FLAGS_RESET = 8'h00;
  localparam logic [7:0] ERROR_FLAGS_MASK = 8'hF8;
  // Clock register field positions
  localparam int RATE_MSB = 7;
  localparam int RATE_LSB = 5;
  localparam int RATIO_MSB = 4;
  localparam int RATIO_LSB = 2;
  localparam int SCLK48_BIT = 1;
  localparam int VALID_BIT = 0;
  // System register field positions
  localparam int DC_BLOCK_BIT = 7;
  localparam int UNMUTE_BIT = 5;
  localparam int AUTODETECT_OFF_BIT = 3;
  localparam int SOFT_START_OFF_BIT = 2;
  localparam int DEEMPH_MSB = 1;
  // Error flag positions
  localparam int ERR_MCLK = 7;
  localparam int ERR_PLL = 6;
  localparam int ERR_SCLK = 5;
  localparam int ERR_LRCLK = 4;
  localparam int ERR_SLIP = 3;
  // Sample rate codes
  localparam logic [2:0] RATE_32K = 3'h0;
  localparam logic [2:0] RATE_44K1 = 3'h2;
  localparam logic [2:0] RATE_48K = 3'h3;
  localparam logic [2:0] RATE_176K4 = 3'h6;
  localparam logic [2:0] RATE_192K = 3'h7;
  // Master clock ratio codes and their ratios
  localparam logic [2:0] RATIO_64 = 3'h0;
  localparam logic [2:0] RATIO_128 = 3'h1;
  localparam logic [2:0] RATIO_192 = 3'h2;
  localparam logic [2:0] RATIO_256 = 3'h3;
  localparam logic [2:0] RATIO_384 = 3'h5;
  localparam logic [2:0] RATIO_512 = 3'h6;
  localparam logic [2:0] RATIO_RESERVED = 3'h7;
  localparam logic [9:0] LEN_64 = 10'h040;
  localparam logic [9:0] LEN_128 = 10'h080;
  localparam logic [9:0] LEN_192 = 10'h0C0;
  localparam logic [9:0] LEN_256 = 10'h100;
  localparam logic [9:0] LEN_384 = 10'h180;
  localparam logic [9:0] LEN_512 = 10'h200;
  // Bit clocks per frame
  localparam logic [7:0] BITS_32 = 8'h20;
  localparam logic [7:0] BITS_48 = 8'h30;
  localparam logic [7:0] BITS_64 = 8'h40;
  // Firmware code, value arbitrary
  localparam logic [6:0] FIRMWARE_CODE = 7'h15;
  // Timing
  localparam int CLOCK_MHZ = 200;
  localparam int FRAME_TIMEOUT_US = 100;
  localparam int FRAME_TIMEOUT_CYCLES = FRAME_TIMEOUT_US * CLOCK_MHZ;
  localparam int FS_HZ [8] = '{32000, 38000, 44100, 48000, 88200, 96000, 176400, 192000};
endpackage

// *** audio_clock_config_status.sv ***
// Clock control, firmware id, sticky clock error and system option registers.
// Assumes MCLK on its own clock port; SCLK and LRCLK are pins from an external source.
`timescale 1ns/1ps

// Behaviour
// (RULE_01) Rate field codes eight rates, 48 kHz default
// (RULE_02) Autodetect reports detected rate and ratio
// (RULE_03) Ratio field codes six ratios, 256x default
// (RULE_04) Host avoids 64x/128x at low rates
// (RULE_05) Host avoids 384x/512x at top rates
// (RULE_06) Bit one selects 48x bit clock; with autodetect on, o_sclk_48x follows the detected bit count instead
// (RULE_07) Manual mode: bit zero marks clocks valid
// (RULE_08) Id register reads fixed code, top zero
// (RULE_09) Five sticky error flags, zero after reset
// (RULE_10) Host clears flags, then reads back
// (RULE_11) Bit seven enables DC blocking filter
// (RULE_12) Bit five picks hard or soft unmute
// (RULE_13) Bit three low enables clock autodetect
// (RULE_14) Bit two low enables soft start
// (RULE_15) Two low bits select de-emphasis
// (RULE_16) Errors still present set again after clear
module audio_clock_config_status
  import audio_clock_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = FRAME_TIMEOUT_CYCLES
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_mclk,
  input wire logic i_sclk,
  input wire logic i_lrclk,
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_write,
  input wire logic i_reg_read,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  output logic o_reg_ack,
  output logic [2:0] o_sample_rate,
  output logic [2:0] o_mclk_ratio,
  output logic o_sclk_48x,
  output logic o_clock_valid,
  output logic o_dc_block_en,
  output logic o_hard_unmute,
  output logic o_autodetect_en,
  output logic o_soft_start_en,
  output logic [1:0] o_deemphasis
);

  // ---------------- MCLK domain ----------------
  logic rst_m1, rst_m2;
  logic sclk_m1, sclk_m2, sclk_m3;
  logic lr_m1, lr_m2, lr_m3;
  logic [9:0] mclk_count;
  logic [7:0] sclk_count;
  logic [9:0] link_len;
  logic [7:0] link_bits;
  logic link_slip;
  logic link_toggle;

  // Reset and pin synchronisers on MCLK
  always_ff @(posedge i_mclk) begin
    rst_m1 <= i_rst_n;
    rst_m2 <= rst_m1;
    sclk_m1 <= i_sclk;
    sclk_m2 <= sclk_m1;
    sclk_m3 <= sclk_m2;
    lr_m1 <= i_lrclk;
    lr_m2 <= lr_m1;
    lr_m3 <= lr_m2;
  end

  // Frame measurement: MCLK and SCLK edges per LRCLK period
  always_ff @(posedge i_mclk) begin
    if (!rst_m2) begin
      mclk_count <= 10'h001;
      sclk_count <= 8'h00;
      link_len <= 10'h000;
      link_bits <= 8'h00;
      link_slip <= 1'b0;
      link_toggle <= 1'b0;
    end else if (lr_m2 && !lr_m3) begin
      link_len <= mclk_count;
      link_bits <= sclk_count;
      link_slip <= (link_len != 10'h000) && (link_len != mclk_count); // Length jumped
      link_toggle <= ~link_toggle;
      mclk_count <= 10'h001;
      sclk_count <= 8'h00;
    end else begin
      if (mclk_count != 10'h3FF) begin
        mclk_count <= mclk_count + 10'h001;
      end
      if (sclk_m2 && !sclk_m3 && sclk_count != 8'hFF) begin
        sclk_count <= sclk_count + 8'h01;
      end
    end
  end

  // ---------------- System domain ----------------
  logic tog_s1, tog_s2, tog_s3;
  logic lr_s1, lr_s2, lr_s3;
  logic word_event;
  logic [15:0] lr_age;
  logic [15:0] word_age;
  logic [15:0] lr_period;
  logic lr_seen, word_seen;
  logic [2:0] det_rate, next_det_rate;
  logic [2:0] det_ratio, next_ratio;
  logic det_sclk48;
  logic bits_bad;
  logic lr_timeout, word_timeout;
  logic combo_bad;
  logic det_lock;
  logic [7:0] clock_rate_control;
  logic [7:0] system_options_one;
  logic [7:0] clock_error_flags;
  logic [7:0] error_events;
  logic autodetect_on;
  logic wr_clock, wr_error, wr_system;
  logic [7:0] clock_view;

  // Toggle and LRCLK synchronisers on the system clock
  always_ff @(posedge i_clock) begin
    tog_s1 <= link_toggle;
    tog_s2 <= tog_s1;
    tog_s3 <= tog_s2;
    lr_s1 <= i_lrclk;
    lr_s2 <= lr_s1;
    lr_s3 <= lr_s2;
  end

  // Frame word is stable for a whole frame after its toggle
  assign word_event = tog_s2 ^ tog_s3;

  // Ratio decode of the measured frame length
  always_comb begin
    case (link_len)
      LEN_64: next_ratio = RATIO_64;
      LEN_128: next_ratio = RATIO_128;
      LEN_192: next_ratio = RATIO_192;
      LEN_256: next_ratio = RATIO_256;
      LEN_384: next_ratio = RATIO_384;
      LEN_512: next_ratio = RATIO_512;
      default: next_ratio = RATIO_RESERVED;
    endcase
  end

  // Rate code rises with each midpoint the period falls below
  always_comb begin
    next_det_rate = 3'h0;
    for (int i = 0; i < 7; i++) begin
      if (int'(lr_period) < (CLOCK_MHZ * 1000000 / FS_HZ[i] +
                             CLOCK_MHZ * 1000000 / FS_HZ[i + 1]) / 2) begin
        next_det_rate = next_det_rate + 3'h1;
      end
    end
  end

  // LRCLK period and age timers
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      lr_age <= 16'h0000;
      lr_period <= 16'h0000;
      lr_seen <= 1'b0;
      det_rate <= RATE_48K;
    end else if (lr_s2 && !lr_s3) begin
      lr_age <= 16'h0001;
      lr_period <= lr_age;
      lr_seen <= 1'b1;
      det_rate <= next_det_rate; // see RULE_02
    end else if (lr_age != 16'hFFFF) begin
      lr_age <= lr_age + 16'h0001;
    end
  end

  // Frame word capture and MCLK age
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      word_age <= 16'h0000;
      word_seen <= 1'b0;
      det_ratio <= RATIO_256;
      det_sclk48 <= 1'b0;
    end else if (word_event) begin
      word_age <= 16'h0000;
      word_seen <= 1'b1;
      det_ratio <= next_ratio; // see RULE_02
      det_sclk48 <= (link_bits == BITS_48);
    end else if (word_age != 16'hFFFF) begin
      word_age <= word_age + 16'h0001;
    end
  end

  // Host must avoid these; autodetect sets the PLL error flag for them
  always_comb begin
    combo_bad = 1'b0;
    if (next_ratio == RATIO_64 &&
        (det_rate == RATE_32K || det_rate == RATE_44K1 || det_rate == RATE_48K)) begin
      combo_bad = 1'b1; // see RULE_04
    end
    if (next_ratio == RATIO_128 && det_rate == RATE_32K) begin
      combo_bad = 1'b1; // see RULE_04
    end
    if ((next_ratio == RATIO_384 || next_ratio == RATIO_512) &&
        (det_rate == RATE_176K4 || det_rate == RATE_192K)) begin
      combo_bad = 1'b1; // see RULE_05
    end
  end

  assign bits_bad = (link_bits != BITS_32) && (link_bits != BITS_48) && (link_bits != BITS_64);
  assign lr_timeout = lr_age >= 16'(TIMEOUT_CYCLES);
  assign word_timeout = word_age >= 16'(TIMEOUT_CYCLES);
  assign autodetect_on = !system_options_one[AUTODETECT_OFF_BIT]; // see RULE_13
  assign det_lock = lr_seen && word_seen && !lr_timeout && !word_timeout &&
                    det_ratio != RATIO_RESERVED;

  // Error conditions seen this cycle
  always_comb begin
    error_events = 8'h00;
    error_events[ERR_MCLK] = word_timeout || (word_event && next_ratio == RATIO_RESERVED);
    error_events[ERR_PLL] = autodetect_on && word_event &&
                            (next_ratio == RATIO_RESERVED || combo_bad);
    error_events[ERR_SCLK] = word_event && bits_bad;
    error_events[ERR_LRCLK] = lr_timeout;
    error_events[ERR_SLIP] = word_event && link_slip;
  end

  assign wr_clock = i_reg_write && i_reg_addr == ADDR_CLOCK_RATE;
  assign wr_error = i_reg_write && i_reg_addr == ADDR_ERROR_FLAGS;
  assign wr_system = i_reg_write && i_reg_addr == ADDR_SYSTEM_ONE;

  // Clock register: fields writable, valid bit is the manual handshake
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      clock_rate_control <= CLOCK_RATE_RESET; // see RULE_01
    end else if (wr_clock) begin
      clock_rate_control <= i_reg_wdata; // see RULE_03
    end
  end

  // System options register
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      system_options_one <= SYSTEM_ONE_RESET;
    end else if (wr_system) begin
      system_options_one <= i_reg_wdata;
    end
  end

  // Sticky flags: written zero clears, a new event wins over the clear
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      clock_error_flags <= ERROR_FLAGS_RESET; // see RULE_09
    end else if (wr_error) begin
      clock_error_flags <= ((clock_error_flags & i_reg_wdata) | error_events) &
                           ERROR_FLAGS_MASK; // see RULE_10, see RULE_16
    end else begin
      clock_error_flags <= (clock_error_flags | error_events) & ERROR_FLAGS_MASK; // see RULE_09
    end
  end

  // Clock register view: detected status replaces bits 7..2 under autodetect
  always_comb begin
    clock_view = clock_rate_control;
    if (autodetect_on) begin
      clock_view[RATE_MSB:RATE_LSB] = det_rate; // see RULE_02
      clock_view[RATIO_MSB:RATIO_LSB] = det_ratio;
    end
  end

  // Register read port with one-cycle answer
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_reg_rdata <= 8'h00;
      o_reg_ack <= 1'b0;
    end else begin
      o_reg_ack <= i_reg_read || i_reg_write;
      if (i_reg_read) begin
        case (i_reg_addr)
          ADDR_CLOCK_RATE: o_reg_rdata <= clock_view;
          ADDR_FIRMWARE_ID: o_reg_rdata <= {1'b0, FIRMWARE_CODE}; // see RULE_08
          ADDR_ERROR_FLAGS: o_reg_rdata <= clock_error_flags;
          ADDR_SYSTEM_ONE: o_reg_rdata <= system_options_one;
          default: o_reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  // Registered controls toward the audio processor
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_sample_rate <= RATE_48K;
      o_mclk_ratio <= RATIO_256;
      o_sclk_48x <= 1'b0;
      o_clock_valid <= 1'b0;
      o_dc_block_en <= 1'b1;
      o_hard_unmute <= 1'b1;
      o_autodetect_en <= 1'b1;
      o_soft_start_en <= 1'b1;
      o_deemphasis <= 2'h0;
    end else begin
      o_sample_rate <= clock_view[RATE_MSB:RATE_LSB]; // see RULE_01
      o_mclk_ratio <= clock_view[RATIO_MSB:RATIO_LSB]; // see RULE_03
      o_sclk_48x <= autodetect_on ? det_sclk48 : clock_rate_control[SCLK48_BIT]; // see RULE_06
      o_clock_valid <= autodetect_on ? det_lock : clock_rate_control[VALID_BIT]; // see RULE_07
      o_dc_block_en <= system_options_one[DC_BLOCK_BIT]; // see RULE_11
      o_hard_unmute <= system_options_one[UNMUTE_BIT]; // see RULE_12
      o_autodetect_en <= autodetect_on; // see RULE_13
      o_soft_start_en <= !system_options_one[SOFT_START_OFF_BIT]; // see RULE_14
      o_deemphasis <= system_options_one[DEEMPH_MSB:0]; // see RULE_15
    end
  end

  // ---------------- Checks ----------------
  default_rate_a: assert property (@(posedge i_clock) // see RULE_01
    $rose(i_rst_n) |-> clock_rate_control[RATE_MSB:RATE_LSB] == RATE_48K &&
      clock_rate_control[RATIO_MSB:RATIO_LSB] == RATIO_256)
    else $error("clock register default wrong");

  auto_report_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // see RULE_02
    i_reg_read && i_reg_addr == ADDR_CLOCK_RATE && autodetect_on |=>
      o_reg_rdata[RATE_MSB:RATIO_LSB] == $past({det_rate, det_ratio}))
    else $error("autodetect status not reported");

  manual_valid_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // see RULE_07
    wr_clock && !autodetect_on ##1 !wr_system |=>
      o_clock_valid == $past(i_reg_wdata[VALID_BIT], 2))
    else $error("manual clock valid not followed");

  sclk_ratio_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // see RULE_06
    wr_clock && !autodetect_on ##1 !wr_system |=>
      o_sclk_48x == $past(i_reg_wdata[SCLK48_BIT], 2))
    else $error("bit clock ratio not followed");

  id_code_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // see RULE_08
    i_reg_read && i_reg_addr == ADDR_FIRMWARE_ID |=> o_reg_rdata == {1'b0, FIRMWARE_CODE})
    else $error("firmware id wrong");

  flags_sticky_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // see RULE_09
    !wr_error ##1 1'b1 |-> (clock_error_flags & $past(clock_error_flags)) ==
      $past(clock_error_flags))
    else $error("sticky flag dropped");

  flags_reset_a: assert property (@(posedge i_clock) // see RULE_09
    $rose(i_rst_n) |-> clock_error_flags == 8'h00)
    else $error("flags not zero after reset");

  set_wins_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // see RULE_16
    wr_error && (error_events != 8'h00) |=>
      (clock_error_flags & $past(error_events)) == $past(error_events))
    else $error("event lost on clear");

  dc_block_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // see RULE_11
    wr_system ##1 !wr_system |=> o_dc_block_en == $past(i_reg_wdata[DC_BLOCK_BIT], 2))
    else $error("dc block control not followed");

  options_map_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // see RULE_14
    wr_system ##1 !wr_system |=> o_soft_start_en == !$past(i_reg_wdata[SOFT_START_OFF_BIT], 2)
      && o_autodetect_en == !$past(i_reg_wdata[AUTODETECT_OFF_BIT], 2)
      && o_hard_unmute == $past(i_reg_wdata[UNMUTE_BIT], 2)
      && o_deemphasis == $past(i_reg_wdata[DEEMPH_MSB:0], 2))
    else $error("system options not followed");

endmodule // audio_clock_config_status

// *** audio_clock_source.sv ***
// Behavioural external audio clock source: bit and frame clocks derived from MCLK.
// Assumes i_frame_len is a multiple of twice i_bits; both clocks stand still when disabled.
`timescale 1ns/1ps
module audio_clock_source (
  input wire logic i_mclk,
  input wire logic i_enable,
  input wire logic [9:0] i_frame_len,
  input wire logic [7:0] i_bits,
  output logic o_sclk,
  output logic o_lrclk
);
  logic [9:0] count;
  logic [9:0] per_bit;

  // Position in the frame, held at zero while stopped
  always_ff @(posedge i_mclk) begin
    if (!i_enable || count >= i_frame_len - 10'h001) begin
      count <= 10'h000;
    end else begin
      count <= count + 10'h001;
    end
  end

  assign per_bit = i_frame_len / {2'b00, i_bits};

  // Frame clock high in first half, bit clock high in second half of a bit
  always_comb begin
    o_lrclk = i_enable && (count < (i_frame_len >> 1));
    o_sclk = i_enable && ((count % per_bit) >= (per_bit >> 1));
  end
endmodule // audio_clock_source

// *** audio_clock_config_status_tb.sv ***
// Self-checking bench for the audio clock control and status registers.
// Assumes the plain strobe register port and the behavioural clock source model.
`timescale 1ns/1ps
module audio_clock_config_status_tb;
  import audio_clock_pkg::*;
  localparam int TIMEOUT = 8000;
  localparam int CEILING = 100000;
  localparam logic [2:0] RATIOS [6] = '{RATIO_64, RATIO_128, RATIO_192, RATIO_256,
    RATIO_384, RATIO_512};
  logic i_clock, i_rst_n, i_mclk, i_reg_write, i_reg_read, src_en, sclk, lrclk;
  logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata, rd, bits, clk_pins, sys_pins;
  logic [9:0] frame_len;
  logic [2:0] o_sample_rate, o_mclk_ratio;
  logic [1:0] o_deemphasis;
  logic o_reg_ack, o_sclk_48x, o_clock_valid, o_dc_block_en, o_hard_unmute;
  logic o_autodetect_en, o_soft_start_en;
  int fails = 0;
  int compares = 0;
  int cycles = 0;

  audio_clock_config_status #(.TIMEOUT_CYCLES(TIMEOUT)) uut (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_mclk(i_mclk), .i_sclk(sclk),
    .i_lrclk(lrclk), .i_reg_addr(i_reg_addr), .i_reg_write(i_reg_write),
    .i_reg_read(i_reg_read), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
    .o_reg_ack(o_reg_ack), .o_sample_rate(o_sample_rate), .o_mclk_ratio(o_mclk_ratio),
    .o_sclk_48x(o_sclk_48x), .o_clock_valid(o_clock_valid),
    .o_dc_block_en(o_dc_block_en), .o_hard_unmute(o_hard_unmute),
    .o_autodetect_en(o_autodetect_en), .o_soft_start_en(o_soft_start_en),
    .o_deemphasis(o_deemphasis));

  audio_clock_source src (.i_mclk(i_mclk), .i_enable(src_en), .i_frame_len(frame_len),
    .i_bits(bits), .o_sclk(sclk), .o_lrclk(lrclk));

  // Clock output pins gathered in register layout; system option pins packed into the top four bits, above de-emphasis
  assign clk_pins = {o_sample_rate, o_mclk_ratio, o_sclk_48x, o_clock_valid};
  assign sys_pins = {o_dc_block_en, o_hard_unmute, o_autodetect_en, o_soft_start_en,
    2'b00, o_deemphasis};

  // System clock and unrelated link clock
  initial begin
    i_clock = 1'b0;
    forever #2.5 i_clock = ~i_clock;
  end
  initial begin
    i_mclk = 1'b0;
    #17;
    forever #62.5 i_mclk = ~i_mclk;
  end

  // Hang guard
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == CEILING) begin
      fails++;
      complete_run();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One register access, strobe for one cycle, outputs settled on return
  task automatic acc(input logic wr, input logic [7:0] addr, input logic [7:0] wd);
    @(negedge i_clock);
    i_reg_addr = addr;
    i_reg_wdata = wd;
    i_reg_write = wr;
    i_reg_read = !wr;
    @(negedge i_clock);
    // Answer stands for one cycle after the taking edge
    check({7'h00, o_reg_ack}, 8'h01);
    rd = o_reg_rdata;
    i_reg_write = 1'b0;
    i_reg_read = 1'b0;
    @(negedge i_clock);
    check({7'h00, o_reg_ack}, 8'h00);
    @(negedge i_clock);
  endtask

  task automatic rdc(input logic [7:0] addr, input logic [7:0] exp);
    acc(1'b0, addr, 8'h00);
    check(rd, exp);
  endtask

  task automatic reset_values();
    check(clk_pins, CLOCK_RATE_RESET);
    check(sys_pins, 8'hF0);
    rdc(ADDR_SYSTEM_ONE, SYSTEM_ONE_RESET);
    rdc(ADDR_ERROR_FLAGS, ERROR_FLAGS_RESET);
    rdc(8'h7F, 8'h00);
    acc(1'b1, ADDR_FIRMWARE_ID, 8'hFF);
    rdc(ADDR_FIRMWARE_ID, {1'b0, FIRMWARE_CODE});
  endtask

  task automatic system_options();
    acc(1'b1, ADDR_SYSTEM_ONE, 8'h00);
    check(sys_pins, 8'h30);
    for (int d = 0; d < 4; d++) begin
      acc(1'b1, ADDR_SYSTEM_ONE, 8'hAC | d[7:0]);
      check(sys_pins, 8'hC0 | d[7:0]);
      rdc(ADDR_SYSTEM_ONE, 8'hAC | d[7:0]);
    end
  endtask

  // Manual mode, legal combinations only
  task automatic manual_clock();
    for (int r = 0; r < 8; r++) begin
      acc(1'b1, ADDR_CLOCK_RATE, {r[2:0], RATIO_256, 2'b00});
      check(clk_pins, {r[2:0], RATIO_256, 2'b00});
    end
    for (int k = 0; k < 6; k++) begin
      acc(1'b1, ADDR_CLOCK_RATE, {3'h5, RATIOS[k], 2'b00});
      check(clk_pins, {3'h5, RATIOS[k], 2'b00});
    end
    acc(1'b1, ADDR_CLOCK_RATE, {RATE_48K, RATIO_192, 2'b11});
    check(clk_pins, {RATE_48K, RATIO_192, 2'b11});
    rdc(ADDR_CLOCK_RATE, {RATE_48K, RATIO_192, 2'b11});
  endtask

  task automatic sticky_detect();
    repeat (TIMEOUT + 500) @(negedge i_clock);
    acc(1'b1, ADDR_ERROR_FLAGS, 8'hFF);
    acc(1'b0, ADDR_ERROR_FLAGS, 8'h00);
    check(rd & 8'h97, 8'h90);
    acc(1'b1, ADDR_SYSTEM_ONE, 8'hA0);
    frame_len = LEN_256;
    bits = BITS_64;
    src_en = 1'b1;
    repeat (20000) @(negedge i_clock);
    rdc(ADDR_CLOCK_RATE, {RATE_32K, RATIO_256, 2'b11});
    check(clk_pins, {RATE_32K, RATIO_256, 2'b01});
    // Start-up frame was overlong and bit-less, so every flag is set by now
    acc(1'b0, ADDR_ERROR_FLAGS, 8'h00);
    check(rd, 8'hF8);
    acc(1'b1, ADDR_ERROR_FLAGS, 8'h00);
    repeat (14000) @(negedge i_clock);
    rdc(ADDR_ERROR_FLAGS, 8'h00);
    frame_len = LEN_192;
    repeat (20000) @(negedge i_clock);
    rdc(ADDR_CLOCK_RATE, {RATE_44K1, RATIO_192, 2'b11});
    acc(1'b0, ADDR_ERROR_FLAGS, 8'h00);
    check(rd & 8'h08, 8'h08);
    src_en = 1'b0;
    acc(1'b1, ADDR_ERROR_FLAGS, 8'h00);
    repeat (TIMEOUT + 500) @(negedge i_clock);
    acc(1'b0, ADDR_ERROR_FLAGS, 8'h00);
    check(rd & 8'h10, 8'h10);
  endtask

  task automatic complete_run();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Main sequence; reset long enough for the link domain to see it
  initial begin
    i_rst_n = 1'b0;
    i_reg_addr = 8'h00;
    i_reg_wdata = 8'h00;
    i_reg_write = 1'b0;
    i_reg_read = 1'b0;
    src_en = 1'b0;
    frame_len = LEN_256;
    bits = BITS_64;
    repeat (80) @(negedge i_clock);
    i_rst_n = 1'b1;
    @(negedge i_clock);
    reset_values();
    system_options();
    manual_clock();
    sticky_detect();
    complete_run();
  end
endmodule // audio_clock_config_status_tb
